// ---- hdl/i2c_line_sampler.sv ----
// registers scl/sda once and reports clock edges, start and stop conditions
`timescale 1ns/1ps
`default_nettype none
module i2c_line_sampler
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // raw bus levels
    input  wire logic scl_in,
    input  wire logic sda_in,
    // decoded events
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det,
    output logic      sda_level
);
    logic scl_q;
    logic sda_q;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    assign scl_rise  = scl_in & ~scl_q;
    assign scl_fall  = ~scl_in & scl_q;
    // sda moving while scl holds high marks a bus condition, not data
    assign start_det = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_det  = scl_in & scl_q & ~sda_q & sda_in;
    assign sda_level = sda_in;
endmodule
`default_nettype wire

// ---- hdl/i2c_register_access_slave.sv ----
// i2c slave giving a host byte access to an internal register file
// Operation
// - device acknowledges after an address byte that matches it; a read address only after a valid register address
// - register address acknowledged only if valid, otherwise not-acknowledged
// - single write: one or two data bytes, each acknowledged, then STOP
// - burst write: N data bytes, each acknowledged, then STOP
// - after read address ack, device shifts out eight register bits
// - burst read: device sends bytes while master acknowledges each
// - the receiving side acknowledges each accepted byte; the master nacks the last byte of a read
// - ack: sda low before ninth clock rise, held through its high phase
// - nack: sda released high for the whole ninth clock
// - address is five fixed bits plus two address-select pins
// - sda stable while scl high; changes there are START or STOP
`timescale 1ns/1ps
`default_nettype none
module i2c_register_access_slave
    import i2c_slave_pkg::*;
#(
    parameter int NUM_REGS = 32
)
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // i2c bus, open drain
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // address straps
    input  wire logic       addr_select_hi_pin,
    input  wire logic       addr_select_lo_pin,
    // register file user side
    input  wire logic [7:0] reg_rd_data,
    output logic [7:0]      reg_index,
    output logic [7:0]      reg_wr_data,
    output logic            reg_wr_stb,
    output logic            reg_rd_stb
);
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_DEVADDR = 3'b001,
        ST_REGADDR = 3'b010,
        ST_WDATA   = 3'b011,
        ST_RDATA   = 3'b100,
        ST_ACK_TX  = 3'b101,
        ST_ACK_RX  = 3'b110
    } state_t;

    state_t     state_q;
    state_t     after_ack_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic       ack_ok_q;
    logic       sda_oe_q;
    logic [7:0] wr_data_q;
    logic       wr_stb_q;
    logic       rd_stb_q;
    logic       ptr_valid_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       sda_level;

    function automatic logic [7:0] next_ptr(input logic [7:0] p);
        // fifo data register keeps its index so blocks stream through it
        next_ptr = (p == REG_FIFO_DATA) ? p : p + 8'h01;
    endfunction

    function automatic logic reg_valid(input logic [7:0] a);
        reg_valid = (a <= REG_LAST_VALID) && (a < 8'(NUM_REGS));
    endfunction

    i2c_line_sampler u_sampler
    (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det),
        .sda_level (sda_level)
    );

    // bit sampling, byte framing and protocol state
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_q     <= ST_IDLE;
            after_ack_q <= ST_IDLE;
            bit_cnt_q   <= 4'h0;
            shift_q     <= 8'h00;
            ack_ok_q    <= 1'b0;
            ptr_valid_q <= 1'b0;
        end
        else if (start_det)
        begin
            // start or repeated start always reframes onto the address byte
            state_q   <= ST_DEVADDR;
            bit_cnt_q <= 4'h0;
        end
        else if (stop_det)
        begin
            state_q     <= ST_IDLE;
            ptr_valid_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    bit_cnt_q <= 4'h0;
                end
                ST_DEVADDR, ST_REGADDR, ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_q   <= {shift_q[6:0], sda_level};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_q == BIT_COUNT_LAST)
                    begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == ST_DEVADDR)
                        begin
                            if (shift_q[0] && ptr_valid_q)
                                after_ack_q <= ST_RDATA;
                            else if (shift_q[0])
                                after_ack_q <= ST_IDLE;
                            else
                                after_ack_q <= ST_REGADDR;
                            ack_ok_q <= (shift_q[7:1] ==
                                {SLAVE_ADDR_HI, addr_select_hi_pin,
                                 addr_select_lo_pin}) &&
                                (!shift_q[0] || ptr_valid_q);
                        end
                        else if (state_q == ST_REGADDR)
                        begin
                            ack_ok_q    <= reg_valid(shift_q);
                            ptr_valid_q <= reg_valid(shift_q);
                            after_ack_q <= ST_WDATA;
                        end
                        else
                        begin
                            ack_ok_q    <= 1'b1;
                            after_ack_q <= ST_WDATA;
                        end
                        state_q <= ST_ACK_TX;
                    end
                end
                ST_ACK_TX:
                begin
                    // ack bit is held from this fall until the ninth clock falls
                    if (scl_fall)
                    begin
                        state_q   <= ack_ok_q ? after_ack_q : ST_IDLE;
                        bit_cnt_q <= 4'h0;
                    end
                end
                ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == 4'h7)
                            state_q <= ST_ACK_RX;
                    end
                end
                ST_ACK_RX:
                begin
                    if (scl_rise)
                        ack_ok_q <= ~sda_level;
                    else if (scl_fall)
                    begin
                        bit_cnt_q <= 4'h0;
                        // a nack from the master ends the read
                        state_q <= ack_ok_q ? ST_RDATA : ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // register pointer and register-file strobes
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ptr_q     <= REG_RESET_VALUE;
            wr_data_q <= 8'h00;
            wr_stb_q  <= 1'b0;
            rd_stb_q  <= 1'b0;
        end
        else
        begin
            wr_stb_q <= 1'b0;
            rd_stb_q <= 1'b0;
            if (!start_det && !stop_det && scl_fall)
            begin
                if (state_q == ST_REGADDR && bit_cnt_q == BIT_COUNT_LAST)
                    ptr_q <= shift_q;
                // a burst running past the last register is acked but not stored
                else if (state_q == ST_WDATA && bit_cnt_q == BIT_COUNT_LAST
                         && ptr_valid_q && reg_valid(ptr_q))
                begin
                    wr_data_q <= shift_q;
                    wr_stb_q  <= 1'b1;
                end
                else if (state_q == ST_ACK_TX && after_ack_q == ST_RDATA && ack_ok_q)
                    rd_stb_q <= 1'b1;
                else if (state_q == ST_ACK_RX && ack_ok_q)
                begin
                    ptr_q    <= next_ptr(ptr_q);
                    rd_stb_q <= 1'b1;
                end
            end
            if (wr_stb_q)
                ptr_q <= next_ptr(ptr_q);
        end
    end

    // drive the ack and read bits onto sda; read data settles one cycle after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            sda_oe_q <= 1'b0;
        else if (start_det || stop_det)
            sda_oe_q <= 1'b0;
        else if (state_q == ST_ACK_TX)
            sda_oe_q <= ack_ok_q;
        else if (state_q == ST_RDATA)
            sda_oe_q <= ~reg_rd_data[3'(7 - bit_cnt_q[2:0])];
        else
            sda_oe_q <= 1'b0;
    end

    assign sda_out     = 1'b0;
    assign sda_oe      = sda_oe_q;
    assign reg_index   = ptr_q;
    assign reg_wr_data = wr_data_q;
    assign reg_wr_stb  = wr_stb_q;
    assign reg_rd_stb  = rd_stb_q;
endmodule
`default_nettype wire

// ---- hdl/i2c_slave_pkg.sv ----
// constants shared by the register-access i2c slave
`default_nettype none
package i2c_slave_pkg;
    localparam logic [4:0] SLAVE_ADDR_HI   = 5'h0B;   // fixed upper five address bits
    localparam int         REG_ADDR_W      = 8;
    localparam int         DATA_W          = 8;
    localparam logic [7:0] REG_LAST_VALID  = 8'h1F;   // highest valid register index
    localparam logic [7:0] REG_FIFO_DATA   = 8'h00;   // pointer does not advance here
    localparam logic [3:0] BIT_COUNT_LAST  = 4'h8;    // count after the eighth clock rise
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
endpackage
`default_nettype wire

// ---- sim/i2c_host_model.sv ----
// i2c bus master model: drives scl, pulls sda low, released sda reads as pull-up high
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(parameter int H = 5)
(
    // clock and bus
    input  wire logic sys_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // also a repeated start, entered with scl low
    task automatic start();
        sda_low <= 1'b0;
        tick(H);
        scl <= 1'b1;
        tick(H);
        sda_low <= 1'b1;
        tick(H);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        tick(H);
        scl <= 1'b1;
        tick(H);
        sda_low <= 1'b0;
        tick(H);
    endtask
    // sda set only while scl low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        sda_low <= !b;
        tick(H);
        scl <= 1'b1;
        tick(2);
        s = sda_line;
        tick(H - 2);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, ack);
    endtask
    task automatic rd(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask
endmodule
`default_nettype wire

// ---- sim/i2c_register_access_slave_asserts.sv ----
// port-level assertions for the register-access i2c slave
`timescale 1ns/1ps
`default_nettype none
module i2c_register_access_slave_asserts
    import i2c_slave_pkg::*;
(
    // clock, reset and bus
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       addr_select_hi_pin,
    input wire logic       addr_select_lo_pin,
    // register file side
    input wire logic [7:0] reg_rd_data,
    input wire logic [7:0] reg_index,
    input wire logic [7:0] reg_wr_data,
    input wire logic       reg_wr_stb,
    input wire logic       reg_rd_stb
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_rst;
        $fell(sys_rst) |-> !sda_oe && !reg_wr_stb && !reg_rd_stb && reg_index == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_out0;
        sda_out == 1'b0;
    endproperty
    a_out0: assert property (p_out0) else $error("sda_out not low");
    property p_wstb;
        reg_wr_stb |=> !reg_wr_stb;
    endproperty
    a_wstb: assert property (p_wstb) else $error("write strobe too long");
    property p_rstb;
        reg_rd_stb |=> !reg_rd_stb;
    endproperty
    a_rstb: assert property (p_rstb) else $error("read strobe too long");
    // two settled high samples of scl: the slave may not move sda there
    property p_stable;
        scl_in && $past(scl_in) |-> $stable(sda_oe);
    endproperty
    a_stable: assert property (p_stable) else $error("sda moved while scl high");
    property p_inc;
        reg_wr_stb && reg_index != REG_FIFO_DATA |-> ##[1:2] reg_index == $past(reg_index) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("pointer did not advance");
    property p_hold;
        reg_wr_stb && reg_index == REG_FIFO_DATA |=> (reg_index == REG_FIFO_DATA) [*2];
    endproperty
    a_hold: assert property (p_hold) else $error("pointer left fifo register");
    property p_valid;
        reg_wr_stb |-> reg_index <= REG_LAST_VALID;
    endproperty
    a_valid: assert property (p_valid) else $error("write to invalid register");
    c_wr: cover property (reg_wr_stb && reg_index == REG_FIFO_DATA);
    c_rd: cover property (reg_rd_stb);
    c_ack: cover property ($rose(sda_oe));
endmodule
bind i2c_register_access_slave i2c_register_access_slave_asserts chk_i
(
    .sys_clk            (sys_clk),
    .sys_rst            (sys_rst),
    .scl_in             (scl_in),
    .sda_in             (sda_in),
    .sda_out            (sda_out),
    .sda_oe             (sda_oe),
    .addr_select_hi_pin (addr_select_hi_pin),
    .addr_select_lo_pin (addr_select_lo_pin),
    .reg_rd_data        (reg_rd_data),
    .reg_index          (reg_index),
    .reg_wr_data        (reg_wr_data),
    .reg_wr_stb         (reg_wr_stb),
    .reg_rd_stb         (reg_rd_stb)
);
`default_nettype wire

// ---- sim/i2c_register_access_slave_tb_top.sv ----
// self-checking bench for the register-access i2c slave
`timescale 1ns/1ps
`default_nettype none
module i2c_register_access_slave_tb_top;
    import i2c_slave_pkg::*;
    localparam logic [7:0] SILICON_REVISION_REGISTER = 8'h1F;
    localparam logic [3:0] REV_UPPER                 = 4'h6;   // arbitrary revision nibble
    logic       sys_clk, sys_rst, hi, lo, scl, sda_low, sda_oe, sda_out, wstb, rstb;
    logic [7:0] last_rd;
    logic [7:0] idx, wdat, regs [32], mem_e [32];
    logic [31:0] seed;
    int         error_cnt, check_count, cyc, wstb_cnt, rstb_cnt;
    // open drain: the slave pulls low only when enabled with a low data bit
    wire        sda = !(sda_low || (sda_oe && !sda_out));
    wire  [7:0] rdat = regs[idx[4:0]];
    i2c_host_model host_i (.sys_clk(sys_clk), .sda_line(sda), .scl(scl), .sda_low(sda_low));
    i2c_register_access_slave i2c_register_access_slave_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_select_hi_pin(hi), .addr_select_lo_pin(lo), .reg_rd_data(rdat),
        .reg_index(idx), .reg_wr_data(wdat), .reg_wr_stb(wstb), .reg_rd_stb(rstb));
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        if (wstb === 1'b1) regs[idx[4:0]] <= wdat;
        if (wstb === 1'b1) wstb_cnt <= wstb_cnt + 1;
        if (rstb === 1'b1) rstb_cnt <= rstb_cnt + 1;
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            give_verdict();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [7:0] adr(input logic rw);
        return {SLAVE_ADDR_HI, hi, lo, rw};
    endfunction
    function automatic logic [7:0] nxt(input logic [7:0] p);
        return (p == REG_FIFO_DATA) ? p : p + 8'h01;
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic txn(input logic [7:0] ra, input int n, input logic rd, input logic ok);
        logic a;
        logic [7:0] d, p;
        int w0, r0;
        w0 = wstb_cnt;
        r0 = rstb_cnt;
        host_i.start();
        host_i.wr(adr(1'b0), a);
        check("addr_ack", {7'h0, a}, 8'h00);
        host_i.wr(ra, a);
        check("reg_ack", {7'h0, a}, {7'h0, !ok});
        p = ra;
        if (rd)
        begin
            host_i.start();
            host_i.wr(adr(1'b1), a);
            check("rd_addr_ack", {7'h0, a}, 8'h00);
        end
        for (int k = 0; k < n; k++)
        begin
            if (rd) host_i.rd(k == n - 1, d);
            if (rd) check("rd_data", d, mem_e[p[4:0]]);
            if (rd) last_rd = d;
            seed = lfsr(seed);
            if (!rd) host_i.wr(seed[7:0], a);
            if (!rd) check("wr_ack", {7'h0, a}, 8'h00);
            if (!rd) mem_e[p[4:0]] = seed[7:0];
            p = nxt(p);
        end
        host_i.stop();
        check("wr_strobes", 8'(wstb_cnt - w0), 8'(rd ? 0 : n));
        check("rd_strobes", 8'(rstb_cnt - r0), 8'(rd ? n : 0));
        $display("test done reg %h count %0d read %0d", ra, n, rd);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        logic a;
        logic rdy;
        sys_rst = 1'b1;
        hi = 1'b0;
        lo = 1'b0;
        seed = 32'h4dc0_0ec4;
        error_cnt = 0;
        check_count = 0;
        cyc = 0;
        wstb_cnt = 0;
        rstb_cnt = 0;
        for (int i = 0; i < 32; i++) regs[i] = REG_RESET_VALUE;
        for (int i = 0; i < 32; i++) mem_e[i] = REG_RESET_VALUE;
        regs[SILICON_REVISION_REGISTER[4:0]] = {REV_UPPER, 4'h3};
        mem_e[SILICON_REVISION_REGISTER[4:0]] = {REV_UPPER, 4'h3};
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        // host polls the revision register; only its upper nibble is trusted
        rdy = 1'b0;
        for (int i = 0; i < 4 && !rdy; i++)
        begin
            txn(SILICON_REVISION_REGISTER, 1, 1'b1, 1'b1);
            rdy = last_rd[7:4] == REV_UPPER;
        end
        check("rev_upper", {4'h0, last_rd[7:4]}, {4'h0, REV_UPPER});
        // foreign address must be ignored
        host_i.start();
        host_i.wr({~SLAVE_ADDR_HI, 3'b000}, a);
        check("foreign_addr", {7'h0, a}, 8'h01);
        host_i.stop();
        // a read with no register address in this transfer is refused
        host_i.start();
        host_i.wr(adr(1'b1), a);
        check("rd_no_reg", {7'h0, a}, 8'h01);
        host_i.stop();
        $display("test done foreign address and unaddressed read");
        for (int t = 0; t < 4; t++)
        begin
            hi <= t[1];
            lo <= t[0];
            seed = lfsr(seed);
            @(posedge sys_clk);
            txn(8'(1 + seed[4:0] % 28), 1 + t % 3, 1'b0, 1'b1);
            txn(8'(1 + seed[4:0] % 28), 1 + t % 3, 1'b1, 1'b1);
        end
        seed = lfsr(seed);
        txn(8'h20 | seed[7:0], 0, 1'b0, 1'b0);
        txn(8'h00, 2, 1'b0, 1'b1);
        txn(8'h00, 2, 1'b1, 1'b1);
        txn(8'h1e, 2, 1'b1, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
